// *** src/pcps_pkg.sv ***
// Package for the clock programming sequencer: register map, fields, types
package pcps_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_MODE_A = 8'h18;
  localparam logic [7:0] IDX_MODE_B = 8'h19;
  localparam logic [7:0] IDX_CLK_SEL = 8'h1A;
  localparam logic [7:0] IDX_PTR = 8'h2C;
  localparam logic [7:0] IDX_PIX_DATA = 8'h2D;
  localparam logic [7:0] IDX_MEM_DATA = 8'h2E;
  localparam logic [7:0] IDX_LOOP_DATA = 8'h2F;
  localparam logic [7:0] IDX_MEM_LOOP_CTRL = 8'h39;
  localparam logic [7:0] IDX_PIN_STATUS = 8'h3A;
  // ==========================================================
  // Pointer values
  localparam logic [7:0] PTR_PRESCALE = 8'h00;
  localparam logic [7:0] PTR_POST = 8'h2A;
  localparam logic [7:0] PTR_STATUS = 8'h3F;
  // ==========================================================
  // Field values and positions
  localparam logic [7:0] RCLK_PIXEL_ROUTE = 8'h18;
  localparam logic [7:0] SEL_EXT_EXTERNAL_CLOCK_INPUT_ZERO = 8'h77;
  localparam logic [7:0] SEL_PIXEL_SYNTH = 8'h75;
  localparam logic [2:0] VIDEO_CLOCK_OUT_OFF_CODE = 3'h7;
  localparam int VIDEO_CLOCK_OUT_OFF_LO = 4;
  localparam int RUN_BIT_POS = 3;
  localparam int LOCK_BIT_POS = 6;
  localparam logic [1:0] LEGACY_25 = 2'h0;
  localparam logic [1:0] LEGACY_28 = 2'h1;
  // Legacy pixel settings, numeric N, M, P
  localparam logic [5:0] LEG25_N = 6'h28;
  localparam logic [5:0] LEG25_M = 6'h35;
  localparam logic [1:0] LEG25_P = 2'h3;
  localparam logic [5:0] LEG28_N = 6'h29;
  localparam logic [5:0] LEG28_M = 6'h31;
  localparam logic [1:0] LEG28_P = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_POST = 8'h00;
  // Cycles from run enable with stable settings until lock is flagged
  localparam int LOCK_TIME_US = 100;
  localparam int CLK_MHZ = 10;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic [7:0] pre_in;
    logic [7:0] pre_fb;
    logic [7:0] post;
  } pcps_synth_t;

  typedef struct packed {
    logic [5:0] n;
    logic [5:0] m;
    logic [1:0] p;
    logic run;
  } pcps_setting_t;
endpackage

// *** src/pcps_top.sv ***
// Clock programming sequencer: indexed registers, synth control, lock and routing
// How it works
// - Select pins at 1x apply stored pixel and loop run bits; zero stops oscillators.
// - Select pins 00 or 01 force hard-wired 25.057 or 28.636 MHz pixel settings.
// - Writing 18h to index 39 routes pixel synthesizer to the return clock.
// - Writing 77h to index 1A picks external clock zero as pixel source.
// - Writing 75h to index 1A picks the pixel synthesizer as pixel source.
// - Bits 6..4 of index 1A at 111 disable the video clock output.
// - Pointer at 2C: 0 prescalers, 2A post-scalers, 3F status.
// - Three writes to a data port load input, feedback, post values in order.
// - Status read shows bit 6 once the synthesizer has locked.
// - Device uses low six bits of N, M and low two bits of post.
`timescale 1ns/1ps
`default_nettype none
module pcps_top
  import pcps_pkg::*;
#(
  parameter int LOCK_CNT = pcps_pkg::LOCK_CYCLES
)(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [9:0] avm_address_in,
  input wire logic avm_read_in,
  input wire logic avm_write_in,
  input wire logic [31:0] avm_writedata_in,
  input wire logic [3:0] avm_byteenable_in,
  output logic [31:0] avm_readdata_out,
  output logic avm_waitrequest_out,
  input wire logic [1:0] clock_select_pins_in,
  output pcps_pkg::pcps_setting_t pixel_setting_out,
  output pcps_pkg::pcps_setting_t loop_setting_out,
  output pcps_pkg::pcps_setting_t mem_setting_out,
  output logic [2:0] loop_q_div_out,
  output logic pixel_from_ext_clk_out,
  output logic video_clock_out_en_out,
  output logic rclk_pixel_route_out,
  output logic [7:0] mode_a_out,
  output logic [7:0] mode_b_out
);
  import pcps_pkg::*;

  // The lock timer is sixteen bits wide
  if (LOCK_CNT < 1 || LOCK_CNT > 65535)
  begin : g_bad_lock_cnt
    $error("LOCK_CNT out of range");
  end

  // ==========================================================
  // Pin synchroniser
  logic [1:0] sel_meta_q, sel_meta_d, sel_q, sel_d;
  always_comb
  begin
    sel_meta_d = clock_select_pins_in;
    sel_d = sel_meta_q;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sel_meta_q <= 2'h0;
      sel_q <= 2'h0;
    end
    else
    begin
      sel_meta_q <= sel_meta_d;
      sel_q <= sel_d;
    end
  end

  // ==========================================================
  // Register file; synths 0 pixel, 1 memory, 2 loop
  logic [7:0] mode_a_q, mode_a_d, mode_b_q, mode_b_d;
  logic [7:0] clk_sel_q, clk_sel_d, ptr_q, ptr_d, ml_ctrl_q, ml_ctrl_d;
  pcps_synth_t syn_q [3], syn_d [3];
  logic [1:0] seq_q [3], seq_d [3];
  logic [2:0] locked;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d, wreq_q, wreq_d;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic acc;

  assign idx = avm_address_in[9:2];
  assign wbyte = avm_writedata_in[7:0];
  // Single-cycle wait: request accepted on the second edge it is held
  assign acc = (avm_read_in || avm_write_in) && wait_q;

  function automatic logic [7:0] port_rd(input pcps_synth_t s, input logic [1:0] seq,
                                         input logic [7:0] ptr, input logic lk);
    logic [7:0] r;
    r = 8'h00;
    if (ptr == PTR_STATUS)
    begin
      r[LOCK_BIT_POS] = lk;
    end
    else if (ptr == PTR_POST)
    begin
      r = s.post;
    end
    else
    begin
      case (seq)
        2'h0: r = s.pre_in;
        2'h1: r = s.pre_fb;
        default: r = s.post;
      endcase
    end
    return r;
  endfunction

  always_comb
  begin
    mode_a_d = mode_a_q;
    mode_b_d = mode_b_q;
    clk_sel_d = clk_sel_q;
    ptr_d = ptr_q;
    ml_ctrl_d = ml_ctrl_q;
    syn_d = syn_q;
    seq_d = seq_q;
    rdata_d = rdata_q;
    wait_d = (avm_read_in || avm_write_in) && !wait_q;
    wreq_d = !wait_d;
    if (acc && avm_write_in && avm_byteenable_in[0])
    begin
      case (idx)
        IDX_MODE_A: mode_a_d = wbyte;
        IDX_MODE_B: mode_b_d = wbyte;
        IDX_CLK_SEL: clk_sel_d = wbyte;
        IDX_PTR:
        begin
          ptr_d = wbyte;
          for (int i = 0; i < 3; i++)
          begin
            seq_d[i] = 2'h0;
          end
        end
        IDX_MEM_LOOP_CTRL: ml_ctrl_d = wbyte;
        default: ;
      endcase
      for (int i = 0; i < 3; i++)
      begin
        if (idx == IDX_PIX_DATA + 8'(i))
        begin
          if (ptr_q == PTR_POST)
          begin
            syn_d[i].post = wbyte;
          end
          else if (ptr_q != PTR_STATUS)
          begin
            case (seq_q[i])
              2'h0: syn_d[i].pre_in = wbyte;
              2'h1: syn_d[i].pre_fb = wbyte;
              default: syn_d[i].post = wbyte;
            endcase
            seq_d[i] = (seq_q[i] == 2'h2) ? 2'h0 : seq_q[i] + 2'h1;
          end
        end
      end
    end
    // Read data are captured on the first edge so they stand while waitrequest is low
    if (avm_read_in && !wait_q)
    begin
      rdata_d = 32'h0000_0000;
      case (idx)
        IDX_MODE_A: rdata_d[7:0] = mode_a_q;
        IDX_MODE_B: rdata_d[7:0] = mode_b_q;
        IDX_CLK_SEL: rdata_d[7:0] = clk_sel_q;
        IDX_PTR: rdata_d[7:0] = ptr_q;
        IDX_MEM_LOOP_CTRL: rdata_d[7:0] = ml_ctrl_q;
        IDX_PIN_STATUS: rdata_d[1:0] = sel_q;
        IDX_PIX_DATA: rdata_d[7:0] = port_rd(syn_q[0], seq_q[0], ptr_q, locked[0]);
        IDX_MEM_DATA: rdata_d[7:0] = port_rd(syn_q[1], seq_q[1], ptr_q, locked[1]);
        IDX_LOOP_DATA: rdata_d[7:0] = port_rd(syn_q[2], seq_q[2], ptr_q, locked[2]);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      mode_a_q <= RST_REG;
      mode_b_q <= RST_REG;
      clk_sel_q <= RST_REG;
      ptr_q <= RST_REG;
      ml_ctrl_q <= RST_REG;
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b0;
      wreq_q <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
        syn_q[i] <= '{pre_in: RST_REG, pre_fb: RST_REG, post: RST_POST};
        seq_q[i] <= 2'h0;
      end
    end
    else
    begin
      mode_a_q <= mode_a_d;
      mode_b_q <= mode_b_d;
      clk_sel_q <= clk_sel_d;
      ptr_q <= ptr_d;
      ml_ctrl_q <= ml_ctrl_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      wreq_q <= wreq_d;
      syn_q <= syn_d;
      seq_q <= seq_d;
    end
  end

  // ==========================================================
  // Applied settings and lock timers
  // Pixel and loop run bits only latch while pins sit at 1x, so software
  // can stage a stop without disturbing a running clock.
  logic pix_run_q, pix_run_d, loop_run_q, loop_run_d;
  pcps_setting_t eff [3];
  pcps_setting_t eff_prev_q [3], eff_prev_d [3];
  logic [15:0] lk_cnt_q [3], lk_cnt_d [3];

  always_comb
  begin
    pix_run_d = pix_run_q;
    loop_run_d = loop_run_q;
    if (sel_q[1])
    begin
      pix_run_d = syn_q[0].post[RUN_BIT_POS];
      loop_run_d = syn_q[2].post[RUN_BIT_POS];
    end
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      eff[i].n = syn_q[i].pre_in[5:0];
      eff[i].m = syn_q[i].pre_fb[5:0];
      eff[i].p = syn_q[i].post[1:0];
      eff[i].run = syn_q[i].post[RUN_BIT_POS];
    end
    eff[0].run = pix_run_q;
    eff[2].run = loop_run_q;
    if (sel_q == LEGACY_25)
    begin
      eff[0] = '{n: LEG25_N, m: LEG25_M, p: LEG25_P, run: 1'b1};
    end
    else if (sel_q == LEGACY_28)
    begin
      eff[0] = '{n: LEG28_N, m: LEG28_M, p: LEG28_P, run: 1'b1};
    end
  end

  // A changed setting or a stopped oscillator restarts the lock timer
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_lock
      always_comb
      begin
        eff_prev_d[g] = eff[g];
        lk_cnt_d[g] = lk_cnt_q[g];
        if (!eff[g].run || eff[g] != eff_prev_q[g])
        begin
          lk_cnt_d[g] = 16'h0000;
        end
        else if (lk_cnt_q[g] != 16'(LOCK_CNT))
        begin
          lk_cnt_d[g] = lk_cnt_q[g] + 16'h0001;
        end
      end
      assign locked[g] = (lk_cnt_q[g] == 16'(LOCK_CNT));
    end
  endgenerate

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pix_run_q <= 1'b0;
      loop_run_q <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        eff_prev_q[i] <= '0;
        lk_cnt_q[i] <= 16'h0000;
      end
    end
    else
    begin
      pix_run_q <= pix_run_d;
      loop_run_q <= loop_run_d;
      eff_prev_q <= eff_prev_d;
      lk_cnt_q <= lk_cnt_d;
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pixel_setting_out <= '0;
      loop_setting_out <= '0;
      mem_setting_out <= '0;
      loop_q_div_out <= 3'h0;
      pixel_from_ext_clk_out <= 1'b0;
      video_clock_out_en_out <= 1'b1;
      rclk_pixel_route_out <= 1'b0;
      mode_a_out <= RST_REG;
      mode_b_out <= RST_REG;
    end
    else
    begin
      pixel_setting_out <= eff[0];
      mem_setting_out <= eff[1];
      loop_setting_out <= eff[2];
      loop_q_div_out <= ml_ctrl_q[2:0];
      pixel_from_ext_clk_out <= (clk_sel_q[3:0] == SEL_EXT_EXTERNAL_CLOCK_INPUT_ZERO[3:0]);
      video_clock_out_en_out <= (clk_sel_q[6:4] != VIDEO_CLOCK_OUT_OFF_CODE);
      rclk_pixel_route_out <= (ml_ctrl_q == RCLK_PIXEL_ROUTE);
      mode_a_out <= mode_a_q;
      mode_b_out <= mode_b_q;
    end
  end

  assign avm_readdata_out = rdata_q;
  assign avm_waitrequest_out = wreq_q;
endmodule
`default_nettype wire

// *** tb/pcps_monitor.sv ***
// Port checker for the clock programming sequencer, bound into pcps_top
`timescale 1ns/1ps
`default_nettype none
module pcps_monitor
  import pcps_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [9:0] avm_address_in,
  input wire logic avm_read_in,
  input wire logic avm_write_in,
  input wire logic [31:0] avm_writedata_in,
  input wire logic [3:0] avm_byteenable_in,
  input wire logic avm_waitrequest_out,
  input wire logic [1:0] clock_select_pins_in,
  input wire pcps_pkg::pcps_setting_t pixel_setting_out,
  input wire pcps_pkg::pcps_setting_t loop_setting_out,
  input wire logic [2:0] loop_q_div_out,
  input wire logic pixel_from_ext_clk_out,
  input wire logic video_clock_out_en_out,
  input wire logic rclk_pixel_route_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  logic wr_ok;
  logic [2:0] wr_lo;
  assign wr_ok = avm_write_in && !avm_waitrequest_out && avm_byteenable_in[0];
  assign wr_lo = avm_writedata_in[2:0];
  // ==========================================================
  // Accepted register writes
  sequence wr_at(logic [7:0] idx, logic [7:0] val);
    wr_ok && avm_address_in[9:2] == idx && avm_writedata_in[7:0] == val;
  endsequence
  AST_WAIT_ONE: assert property ((avm_read_in || avm_write_in) && avm_waitrequest_out
    |=> !avm_waitrequest_out) else $error("request not answered after one cycle");
  AST_WAIT_PULSE: assert property (!avm_waitrequest_out |=> avm_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  // Register-driven outputs show an accepted write one edge after it lands
  AST_RCLK_ROUTE: assert property (wr_at(IDX_MEM_LOOP_CTRL, RCLK_PIXEL_ROUTE) |=> ##1
    rclk_pixel_route_out) else $error("pixel synth not routed to return clock");
  AST_EXT_SEL: assert property (wr_at(IDX_CLK_SEL, SEL_EXT_EXTERNAL_CLOCK_INPUT_ZERO) |=> ##1
    pixel_from_ext_clk_out && !video_clock_out_en_out) else $error("ext clock select wrong");
  AST_SYNTH_SEL: assert property (wr_at(IDX_CLK_SEL, SEL_PIXEL_SYNTH) |=> ##1
    !pixel_from_ext_clk_out) else $error("synth clock select wrong");
  AST_QDIV: assert property (wr_ok && avm_address_in[9:2] == IDX_MEM_LOOP_CTRL |=> ##1
    loop_q_div_out == $past(wr_lo, 2)) else $error("loop extra divider not stored");
  AST_LEGACY_A: assert property (clock_select_pins_in == LEGACY_25 [*5] |->
    pixel_setting_out == {LEG25_N, LEG25_M, LEG25_P, 1'b1}) else $error("legacy 00 wrong");
  AST_LEGACY_B: assert property (clock_select_pins_in == LEGACY_28 [*5] |->
    pixel_setting_out == {LEG28_N, LEG28_M, LEG28_P, 1'b1}) else $error("legacy 01 wrong");
  AST_RUN_HOLD: assert property (!clock_select_pins_in[1] [*5] |=>
    $stable(loop_setting_out.run)) else $error("loop run bit moved with pins low");
endmodule
bind pcps_top pcps_monitor u_mon (.*);
`default_nettype wire

// *** tb/pcps_pin_host.sv ***
// Host-side model driving the clock-select pin pair
`timescale 1ns/1ps
`default_nettype none
module pcps_pin_host (
  input wire logic ref_clk_in,
  input wire logic [1:0] pins_req_in,
  output logic [1:0] clock_select_pins_out
);
  // Pins only move once the bench has cleared run bits, one edge later
  always_ff @(posedge ref_clk_in)
  begin
    clock_select_pins_out <= pins_req_in;
  end
endmodule
`default_nettype wire

// *** tb/pll_clock_programming_sequencer_test.sv ***
// Self-checking bench: mode setup sequences, divider loads and lock polling
`timescale 1ns/1ps
`default_nettype none
module pll_clock_programming_sequencer_test;
  import pcps_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h00000000;
  logic [31:0] rdat;
  logic wreq;
  logic [1:0] pins_req = 2'h0;
  logic [1:0] pins;
  logic [7:0] v;
  pcps_setting_t pix, lp, mem;
  logic [2:0] qdiv;
  logic ext, ven, route;
  logic [7:0] ma, mb;
  int mismatches = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  pcps_pin_host HOST (.ref_clk_in(clk), .pins_req_in(pins_req), .clock_select_pins_out(pins));
  pcps_top #(.LOCK_CNT(8)) DUT (.ref_clk_in(clk), .rst_in(rst), .avm_address_in(addr),
    .avm_read_in(rd), .avm_write_in(wr), .avm_writedata_in(wd), .avm_byteenable_in(4'hF),
    .avm_readdata_out(rdat), .avm_waitrequest_out(wreq), .clock_select_pins_in(pins),
    .pixel_setting_out(pix), .loop_setting_out(lp), .mem_setting_out(mem),
    .loop_q_div_out(qdiv), .pixel_from_ext_clk_out(ext), .video_clock_out_en_out(ven),
    .rclk_pixel_route_out(route), .mode_a_out(ma), .mode_b_out(mb));
  // ==========================================================
  // Tasks
  function automatic pcps_setting_t st(logic [5:0] n, logic [5:0] m, logic [1:0] p);
    return {n, m, p, 1'b1};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read data stand while waitrequest is low and are taken at the accepting edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    addr <= {idx, 2'b00};
    wd <= {24'h000000, d};
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk);
    end
    while (wreq !== 1'b0);
    v = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    // Pixel and loop run bits reach the setting outputs two edges after the write lands
    repeat (3) @(posedge clk);
  endtask
  task automatic load(input logic [7:0] idx, input logic [7:0] a, b, c);
    bus(1'b1, IDX_PTR, PTR_PRESCALE);
    bus(1'b1, idx, a);
    bus(1'b1, idx, b);
    bus(1'b1, idx, c);
  endtask
  task automatic stop_synths();
    bus(1'b1, IDX_PTR, PTR_POST);
    bus(1'b1, IDX_LOOP_DATA, 8'h00);
    bus(1'b1, IDX_PIX_DATA, 8'h00);
    pins_req <= 2'h3;
    repeat (6) @(posedge clk);
    check(32'({pix.run, lp.run}), 32'h0);
  endtask
  task automatic poll(input logic [7:0] idx);
    bus(1'b1, IDX_PTR, PTR_STATUS);
    v = 8'h00;
    for (int k = 0; k < 40 && v[LOCK_BIT_POS] !== 1'b1; k++)
      bus(1'b0, idx, 8'h00);
    check(32'(v[LOCK_BIT_POS]), 32'h1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Watchdog: the whole run needs well under 3000 cycles
  initial
  begin
    #1000000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, IDX_CLK_SEL, SEL_EXT_EXTERNAL_CLOCK_INPUT_ZERO);
    check(32'({ext, ven}), 32'h2);
    bus(1'b1, IDX_MODE_A, 8'h80);
    bus(1'b1, IDX_MODE_B, 8'h98);
    bus(1'b0, IDX_CLK_SEL, 8'h00);
    check({8'h00, ma, mb, v}, 32'h00809877);
    stop_synths();
    for (int i = 0; i < 2; i++)
    begin
      pins_req <= 2'(i);
      repeat (6) @(posedge clk);
      check(32'(pix), 32'(i == 0 ? st(LEG25_N, LEG25_M, LEG25_P)
        : st(LEG28_N, LEG28_M, LEG28_P)));
    end
    bus(1'b1, IDX_MEM_LOOP_CTRL, RCLK_PIXEL_ROUTE);
    check(32'(route), 32'h1);
    $display("test legacy setup done");
    bus(1'b1, IDX_CLK_SEL, SEL_PIXEL_SYNTH);
    check(32'({ext, ven}), 32'h0);
    stop_synths();
    load(IDX_PIX_DATA, 8'hE8, 8'h1C, 8'hB8);
    check(32'(pix), 32'(st(6'h28, 6'h1C, 2'h0)));
    poll(IDX_PIX_DATA);
    bus(1'b1, IDX_MEM_LOOP_CTRL, 8'h32);
    check(32'({route, qdiv}), 32'h2);
    load(IDX_LOOP_DATA, 8'hF9, 8'h3D, 8'hF9);
    check(32'(lp), 32'(st(6'h39, 6'h3D, 2'h1)));
    poll(IDX_LOOP_DATA);
    bus(1'b1, IDX_PTR, PTR_POST);
    bus(1'b0, IDX_PIX_DATA, 8'h00);
    check(32'(v), 32'hB8);
    $display("test extended setup done");
    bus(1'b1, IDX_MEM_DATA, 8'h00);
    check(32'(mem.run), 32'h0);
    load(IDX_MEM_DATA, 8'hE9, 8'h10, 8'hB9);
    check(32'(mem), 32'(st(6'h29, 6'h10, 2'h1)));
    bus(1'b1, IDX_PTR, PTR_POST);
    bus(1'b1, IDX_MEM_DATA, 8'h00);
    check(32'(mem.run), 32'h0);
    bus(1'b0, 8'h10, 8'h00);
    check(32'(v), 32'h0);
    stop_synths();
    $display("test memory and restop done");
    wrap_up();
  end
endmodule
`default_nettype wire
